// >>> rmac_pkg.sv
// Shared constants, types and helpers of the receive MAC block.
// Assumes one 100 MHz clock and an AXI4-Lite master for software.
// What this block does
// - Double-edge error inputs sampled on both edges.
// - Collision honoured only half-duplex 10/100 options.
// - Carrier sense honoured only half-duplex 10/100 options.
// - One write request per byte with data.
// - Statistics vector valid while its enable high.
// - Byte count in statistics bits 15 to 0.
// - Bits 16-19: VLAN, pause, control, bad opcode.
// - Bits 20-23: dribble, broadcast, multicast, OK.
// - Bits 24-27: length, CRC, ignored, carrier seen.
// - Bits 29-31: gap violation, short, long.
// - Core runs at half rate in 10/100.
// - Frame error with end of frame on receive error, CRC or length faults.
// - FIFO full stops writes until frame end drains.
// - Ignore input keeps dropping received packets.
package rmac_pkg;
  localparam logic [4:0]  ADDR_CTRL   = 5'h00;
  localparam logic [4:0]  ADDR_MAXLEN = 5'h04;
  localparam logic [4:0]  ADDR_STAT   = 5'h08;
  localparam logic [4:0]  ADDR_ISTS   = 5'h0C;
  localparam logic [4:0]  ADDR_IMASK  = 5'h10;
  localparam logic [1:0]  OPT_DDR     = 2'h0;
  localparam logic [1:0]  OPT_GMII    = 2'h1;
  localparam logic [1:0]  OPT_SER     = 2'h2;
  localparam logic [5:0]  CTRL_RST    = 6'h01;
  localparam logic [15:0] MAXLEN_RST  = 16'h05EE;
  localparam logic [7:0]  SFD         = 8'hD5;
  localparam logic [15:0] TYPE_VLAN   = 16'h8100;
  localparam logic [15:0] TYPE_CTRL   = 16'h8808;
  localparam logic [15:0] OP_PAUSE    = 16'h0001;
  localparam logic [15:0] LEN_MAX     = 16'h05DC;
  localparam logic [15:0] HDR_FCS     = 16'h0012;
  localparam logic [15:0] MIN_FRAME   = 16'h0040;
  localparam logic [7:0]  IPG_MIN     = 8'h0C;
  localparam logic [31:0] CRC_GOOD    = 32'hDEBB20E3;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_ERR    = 2'h2;
  localparam int          IRQ_EOF     = 0;
  localparam int          IRQ_ERR     = 1;
  localparam int          IRQ_FIFO    = 2;

  // Receive states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_DATA = 2'b10
  } rmac_state_t;

  // Software configuration, bit 5 downward.
  typedef struct packed {
    logic       half;
    logic       gig;
    logic [1:0] opt;
    logic       spare;
    logic       en;
  } rmac_cfg_t;

  // Per-frame statistics vector layout.
  typedef struct packed {
    logic        long_f;
    logic        short_f;
    logic        ipg_v;
    logic        unused;
    logic        carrier;
    logic        ignored;
    logic        crc_err;
    logic        len_err;
    logic        ok;
    logic        mcast;
    logic        bcast;
    logic        dribble;
    logic        bad_op;
    logic        ctrl;
    logic        pause;
    logic        vlan;
    logic [15:0] count;
  } rmac_stat_t;

  // Reflected CRC-32 update over one byte.
  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// >>> rmac_in_pipe.sv
// Input pipeline of the double-edge receive pins.
// Assumes the pins change away from the clock edges that sample them.
`timescale 1ns/1ns
module rmac_in_pipe (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst,
  // Rising-edge copies.
  input  wire logic [7:0] d_pos,
  input  wire logic       dv_pos,
  input  wire logic       er_pos,
  // Falling-edge copies.
  input  wire logic [3:0] d_neg,
  input  wire logic       dv_neg,
  input  wire logic       er_neg,
  // Pipelined copies.
  output logic      [7:0] d_pos_q,
  output logic            dv_pos_q,
  output logic            er_pos_q,
  output logic      [3:0] d_neg_q,
  output logic            dv_neg_q,
  output logic            er_neg_q
);
  // Rising-edge stage.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      d_pos_q  <= 8'h00;
      dv_pos_q <= 1'b0;
      er_pos_q <= 1'b0;
    end else begin
      d_pos_q  <= d_pos;
      dv_pos_q <= dv_pos;
      er_pos_q <= er_pos;
    end
  end

  // Falling-edge stage.
  always_ff @(negedge clock or posedge rst) begin
    if (rst) begin
      d_neg_q  <= 4'h0;
      dv_neg_q <= 1'b0;
      er_neg_q <= 1'b0;
    end else begin
      d_neg_q  <= d_neg;
      dv_neg_q <= dv_neg;
      er_neg_q <= er_neg;
    end
  end
endmodule // rmac_in_pipe

// >>> rmac_rx.sv
// Receive MAC: PHY inputs to FIFO writes and per-frame statistics.
// Assumes synchronous PHY pins and an AXI4-Lite master on the same clock.
`timescale 1ns/1ns
module rmac_rx (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst,
  // Double-edge PHY pins.
  input  wire logic [7:0]  rxd_pos,
  input  wire logic [3:0]  rxd_neg,
  input  wire logic        rxdv_pos,
  input  wire logic        rxdv_neg,
  input  wire logic        rxer_pos,
  input  wire logic        rxer_neg,
  // Single-edge PHY pins.
  input  wire logic [7:0]  rxd,
  input  wire logic        rxdv,
  input  wire logic        rxer,
  input  wire logic        col,
  input  wire logic        crs,
  // Receive FIFO and host side.
  input  wire logic        rx_fifo_full,
  input  wire logic        rx_fifo_eof_out,
  input  wire logic        ignore_next_pkt,
  output logic             rx_write,
  output logic [7:0]       rx_dbout,
  output logic             rx_eof,
  output logic             rx_error,
  output logic             rx_fifo_error,
  output logic [31:0]      rx_stat_vector,
  output logic             rx_stat_en,
  output logic             irq,
  // AXI4-Lite slave.
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // Whole state of the block.
  typedef struct packed {
    rmac_pkg::rmac_state_t st;
    logic        phase;
    logic        ign_s1;
    logic        ign_s2;
    logic [31:0] crc;
    logic [15:0] cnt;
    logic [15:0] tl;
    logic [15:0] op;
    logic        bcast;
    logic        mcast;
    logic        err;
    logic        col_seen;
    logic        car_seen;
    logic        ign;
    logic        ipgv;
    logic        drib;
    logic [7:0]  gap;
    logic        wr;
    logic [7:0]  dout;
    logic        eof;
    logic        ferr;
    logic        fifo_err;
    logic        sen;
    logic [31:0] svec;
    rmac_pkg::rmac_cfg_t cfg;
    logic [15:0] maxlen;
    logic [2:0]  ists;
    logic [2:0]  imask;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } rmac_reg_t;

  rmac_reg_t q;
  rmac_reg_t d;
  rmac_pkg::rmac_stat_t st_v;

  logic [7:0] p_d;
  logic [3:0] n_d;
  logic       p_dv;
  logic       n_dv;
  logic       p_er;
  logic       n_er;

  // Double-edge pins pass through both-edge flops first.
  rmac_in_pipe u_pipe (
    .clock    (clock),
    .rst      (rst),
    .d_pos    (rxd_pos),
    .dv_pos   (rxdv_pos),
    .er_pos   (rxer_pos),
    .d_neg    (rxd_neg),
    .dv_neg   (rxdv_neg),
    .er_neg   (rxer_neg),
    .d_pos_q  (p_d),
    .dv_pos_q (p_dv),
    .er_pos_q (p_er),
    .d_neg_q  (n_d),
    .dv_neg_q (n_dv),
    .er_neg_q (n_er)
  );

  logic       ddr;
  logic       core_en;
  logic       half_ok;
  logic       dv;
  logic       er;
  logic [7:0] byt;
  logic       sof;
  logic       fin;
  logic       crc_bad;
  logic       len_bad;
  logic       wr_take;
  logic       rd_take;

  // Input selection and the half-rate core strobe.
  always_comb begin
    ddr     = q.cfg.opt == rmac_pkg::OPT_DDR;
    core_en = q.cfg.gig | q.phase;
    half_ok = q.cfg.half & ~q.cfg.gig &
              (ddr | q.cfg.opt == rmac_pkg::OPT_SER);
    dv      = q.cfg.en & (ddr ? p_dv : rxdv);
    er      = ddr ? (p_er | n_er) : rxer;
    byt     = rxd;
    if (ddr) begin
      byt = q.cfg.gig ? p_d : {p_d[3:0], n_d};
    end
    sof     = core_en & dv & byt == rmac_pkg::SFD &
              (q.st == rmac_pkg::ST_IDLE | q.st == rmac_pkg::ST_PRE);
    fin     = core_en & ~dv & q.st == rmac_pkg::ST_DATA;
    crc_bad = q.crc != rmac_pkg::CRC_GOOD;
    len_bad = q.tl <= rmac_pkg::LEN_MAX &
              q.cnt < q.tl + rmac_pkg::HDR_FCS;
    wr_take = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
    rd_take = s_axi_arvalid & ~q.rvalid;
  end

  // Statistics vector assembled at frame end.
  always_comb begin
    st_v         = '0;
    st_v.count   = q.cnt;
    st_v.vlan    = q.tl == rmac_pkg::TYPE_VLAN;
    st_v.ctrl    = q.tl == rmac_pkg::TYPE_CTRL;
    st_v.pause   = st_v.ctrl & q.op == rmac_pkg::OP_PAUSE;
    st_v.bad_op  = st_v.ctrl & q.op != rmac_pkg::OP_PAUSE;
    st_v.dribble = q.drib;
    st_v.bcast   = q.bcast;
    st_v.mcast   = q.mcast & ~q.bcast;
    st_v.len_err = len_bad;
    st_v.crc_err = crc_bad;
    st_v.ignored = q.ign;
    st_v.carrier = q.car_seen;
    st_v.unused  = 1'b0;
    st_v.ipg_v   = q.ipgv;
    st_v.short_f = q.cnt < rmac_pkg::MIN_FRAME;
    st_v.long_f  = q.cnt > q.maxlen;
    st_v.ok      = ~(q.err | crc_bad | len_bad | q.col_seen | q.ign |
                     q.fifo_err | st_v.short_f | st_v.long_f);
  end

  // Next-state logic of frame path and register file.
  always_comb begin
    d        = q;
    d.wr     = 1'b0;
    d.eof    = 1'b0;
    d.sen    = 1'b0;
    d.phase  = ~q.phase;
    d.ign_s1 = ignore_next_pkt;
    d.ign_s2 = q.ign_s1;
    if (core_en && q.st == rmac_pkg::ST_IDLE && q.gap != 8'hFF) begin
      d.gap = q.gap + 8'h01;
    end
    if (half_ok && crs && !dv && q.st == rmac_pkg::ST_IDLE) begin
      d.car_seen = 1'b1;
    end
    unique case (q.st)
      rmac_pkg::ST_IDLE: begin
        if (core_en && dv && !sof) begin
          d.st = rmac_pkg::ST_PRE;
        end
      end
      rmac_pkg::ST_PRE: begin
        if (core_en && !dv) begin
          d.st = rmac_pkg::ST_IDLE;
        end
      end
      rmac_pkg::ST_DATA: begin
        if (core_en && dv) begin
          d.cnt = q.cnt + 16'h0001;
          d.crc = rmac_pkg::crc_byte(q.crc, byt);
          d.err = q.err | er;
          d.col_seen = q.col_seen | (half_ok & col);
          d.drib = ddr & ~q.cfg.gig & (p_dv != n_dv);
          if (q.cnt < 16'h0006) begin
            d.bcast = q.bcast & byt == 8'hFF;
          end
          if (q.cnt == 16'h0000) begin
            d.mcast = byt[0];
          end
          if (q.cnt == 16'h000C || q.cnt == 16'h000D) begin
            d.tl = {q.tl[7:0], byt};
          end
          if (q.cnt == 16'h000E || q.cnt == 16'h000F) begin
            d.op = {q.op[7:0], byt};
          end
          if (!q.ign && !q.fifo_err) begin
            if (rx_fifo_full) begin
              d.fifo_err = 1'b1;
            end else begin
              d.wr   = 1'b1;
              d.dout = byt;
            end
          end
        end
        if (fin) begin
          d.st       = rmac_pkg::ST_IDLE;
          d.eof      = 1'b1;
          d.ferr     = q.err | crc_bad | len_bad;
          d.sen      = 1'b1;
          d.svec     = st_v;
          d.car_seen = 1'b0;
          d.gap      = 8'h00;
        end
      end
      default: d.st = rmac_pkg::ST_IDLE;
    endcase
    if (sof) begin
      d.st       = rmac_pkg::ST_DATA;
      d.cnt      = 16'h0000;
      d.crc      = 32'hFFFFFFFF;
      d.tl       = 16'h0000;
      d.op       = 16'h0000;
      d.bcast    = 1'b1;
      d.mcast    = 1'b0;
      d.err      = 1'b0;
      d.col_seen = 1'b0;
      d.drib     = 1'b0;
      d.ign      = q.ign_s2;
      d.ipgv     = q.gap < rmac_pkg::IPG_MIN;
    end
    // A draining frame end releases the FIFO error; a new one wins.
    if (rx_fifo_eof_out && !(d.fifo_err && !q.fifo_err)) begin
      d.fifo_err = 1'b0;
    end
    // Interrupt clears by writing ones; fresh events win.
    if (wr_take && s_axi_awaddr == rmac_pkg::ADDR_ISTS && s_axi_wstrb[0]) begin
      d.ists = q.ists & ~s_axi_wdata[2:0];
    end
    if (d.eof) begin
      d.ists[rmac_pkg::IRQ_EOF] = 1'b1;
    end
    if (d.eof && d.ferr) begin
      d.ists[rmac_pkg::IRQ_ERR] = 1'b1;
    end
    if (d.fifo_err && !q.fifo_err) begin
      d.ists[rmac_pkg::IRQ_FIFO] = 1'b1;
    end
    // Register writes.
    if (s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_take) begin
      d.bvalid = 1'b1;
      d.bresp  = rmac_pkg::RESP_OK;
      unique case (s_axi_awaddr)
        rmac_pkg::ADDR_CTRL: begin
          if (s_axi_wstrb[0]) begin
            d.cfg = s_axi_wdata[5:0];
          end
        end
        rmac_pkg::ADDR_MAXLEN: begin
          if (s_axi_wstrb[0]) begin
            d.maxlen[7:0] = s_axi_wdata[7:0];
          end
          if (s_axi_wstrb[1]) begin
            d.maxlen[15:8] = s_axi_wdata[15:8];
          end
        end
        rmac_pkg::ADDR_IMASK: begin
          if (s_axi_wstrb[0]) begin
            d.imask = s_axi_wdata[2:0];
          end
        end
        rmac_pkg::ADDR_ISTS: d.bresp = rmac_pkg::RESP_OK;
        default: d.bresp = rmac_pkg::RESP_ERR;
      endcase
    end
    // Register reads.
    if (s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_take) begin
      d.rvalid = 1'b1;
      d.rresp  = rmac_pkg::RESP_OK;
      unique case (s_axi_araddr)
        rmac_pkg::ADDR_CTRL:   d.rdata = {26'h0000000, q.cfg};
        rmac_pkg::ADDR_MAXLEN: d.rdata = {16'h0000, q.maxlen};
        rmac_pkg::ADDR_STAT:   d.rdata = q.svec;
        rmac_pkg::ADDR_ISTS:   d.rdata = {29'h00000000, q.ists};
        rmac_pkg::ADDR_IMASK:  d.rdata = {29'h00000000, q.imask};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = rmac_pkg::RESP_ERR;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.st     <= rmac_pkg::ST_IDLE;
      q.gap    <= 8'hFF;
      q.cfg    <= rmac_pkg::CTRL_RST;
      q.maxlen <= rmac_pkg::MAXLEN_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs from the state register; the AXI ready signals decode the request inputs.
  assign rx_write       = q.wr;
  assign rx_dbout       = q.dout;
  assign rx_eof         = q.eof;
  assign rx_error       = q.eof & q.ferr;
  assign rx_fifo_error  = q.fifo_err;
  assign rx_stat_vector = q.svec;
  assign rx_stat_en     = q.sen;
  assign irq            = |(q.ists & q.imask);
  assign s_axi_awready  = wr_take;
  assign s_axi_wready   = wr_take;
  assign s_axi_bvalid   = q.bvalid;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_arready  = rd_take;
  assign s_axi_rvalid   = q.rvalid;
  assign s_axi_rresp    = q.rresp;
  assign s_axi_rdata    = q.rdata;

  // Checks on the frame path.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_fifo_hold;
    rx_fifo_error |-> !rx_write;
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("Write while FIFO error is set.");

  property p_full_stop;
    rx_write |-> !$past(rx_fifo_full);
  endproperty
  a_full_stop: assert property (p_full_stop)
    else $error("Byte written into a full FIFO.");

  property p_stat_eof;
    rx_stat_en |-> rx_eof ##1 !rx_stat_en;
  endproperty
  a_stat_eof: assert property (p_stat_eof)
    else $error("Statistics enable not a pulse at frame end.");

  property p_unused;
    rx_stat_en |-> !rx_stat_vector[28];
  endproperty
  a_unused: assert property (p_unused)
    else $error("Unused statistics bit is set.");

  property p_err_eof;
    rx_error |-> rx_eof;
  endproperty
  a_err_eof: assert property (p_err_eof)
    else $error("Frame error outside end of frame.");

  property p_short;
    rx_stat_en && rx_stat_vector[15:0] < 16'h0040 |-> rx_stat_vector[30];
  endproperty
  a_short: assert property (p_short)
    else $error("Short frame not flagged.");

  property p_crc_err;
    rx_stat_en && (rx_stat_vector[25] || rx_stat_vector[24]) |-> rx_error;
  endproperty
  a_crc_err: assert property (p_crc_err)
    else $error("CRC or length fault without frame error.");

  property p_ok;
    rx_stat_en && rx_stat_vector[23] |-> !rx_error && !rx_stat_vector[30];
  endproperty
  a_ok: assert property (p_ok)
    else $error("Frame reported OK despite a fault.");

  property p_half_rate;
    rx_write && !q.cfg.gig && $stable(q.cfg) |=> !rx_write;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("Back to back writes at 10/100.");

  property p_ignored;
    rx_stat_en && rx_stat_vector[26] |-> !rx_stat_vector[23];
  endproperty
  a_ignored: assert property (p_ignored)
    else $error("Ignored frame reported OK.");

  c_good: cover property (rx_stat_en && rx_stat_vector[23]);
  c_bad:  cover property (rx_eof && rx_error);
  c_fifo: cover property ($rose(rx_fifo_error));
  c_irq:  cover property ($rose(irq));
endmodule // rmac_rx

// >>> rmac_phy_model.sv
// PHY and receive FIFO model beside the receive MAC.
// Assumes the bench calls send and clear and drives stall.
`timescale 1ns/1ns
module rmac_phy_model (
  // Clock.
  input  wire logic       clock,
  // FIFO side.
  input  wire logic       stall,
  input  wire logic       rx_write,
  input  wire logic [7:0] rx_dbout,
  input  wire logic       rx_eof,
  output logic            rx_fifo_full,
  output logic            rx_fifo_eof_out,
  // Receive pins.
  output logic      [7:0] rxd,
  output logic            rxdv,
  output logic            rxer
);
  int          n_wr;
  int          hold = 1;
  logic [15:0] sum;
  logic [4:0]  drain;
  logic        busy;

  // Full is only ever raised by the bench as a fault.
  assign rx_fifo_full = stall;

  initial begin
    {rxd, rxdv, rxer, rx_fifo_eof_out, busy, drain} = '0;
  end

  // Counts written bytes; frame ends leave the FIFO six cycles later.
  // Released data lines toggle so a stale byte never looks valid.
  always @(posedge clock) begin
    if (rx_write === 1'b1) begin
      n_wr <= n_wr + 1;
      sum  <= sum + 16'(rx_dbout);
    end
    drain           <= {drain[3:0], rx_eof === 1'b1};
    rx_fifo_eof_out <= drain[4];
    if (!busy) begin
      rxd <= ~rxd;
    end
  end

  // Clears the byte tally between frames.
  task automatic clear();
    n_wr = 0;
    sum  = 16'h0000;
  endtask

  // Idle gap, preamble, delimiter, then frame bytes; err_at below 0 is none.
  task automatic send(input logic [7:0] f[$], input int err_at,
                      input int gap);
    repeat (gap) @(posedge clock);
    busy = 1'b1;
    for (int i = -8; i < f.size(); i++) begin
      repeat (hold) @(posedge clock);
      rxdv <= 1'b1;
      rxd  <= (i < -1) ? 8'h55 : (i == -1) ? rmac_pkg::SFD : f[i];
      rxer <= (err_at >= 0) && (i == err_at);
    end
    repeat (hold) @(posedge clock);
    rxdv <= 1'b0;
    rxer <= 1'b0;
    busy = 1'b0;
  endtask
endmodule // rmac_phy_model

// >>> rx_mac_receive_side_interface_tb.sv
// Self-checking bench of the receive MAC: frames, statistics, registers.
// Assumes the PHY and FIFO model beside it and one 100 MHz clock.
`timescale 1ns/1ns
module rx_mac_receive_side_interface_tb;
  typedef struct {
    logic [31:0] ev, mk;
    logic [1:0]  dk;
    logic [15:0] ty, op;
    int          plen, erat, gap;
    logic        bad, ign, ee;
  } rmac_row_t;

  logic        clock, rst, col, crs, ignore_next_pkt, stall;
  logic [7:0]  rxd;
  logic        rxdv, rxer, rx_fifo_full, rx_fifo_eof_out;
  logic        rx_write, rx_eof, rx_error, rx_fifo_error, rx_stat_en, irq;
  logic [7:0]  rx_dbout;
  logic [31:0] rx_stat_vector, s_axi_wdata, s_axi_rdata, st_v, d;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, got, st_err, st_eof;
  logic [7:0]  frm[$];
  logic [15:0] esum;
  int          n_errors, comparisons;

  // Ordinary frames: expected vector, compared bits, then the stimulus.
  rmac_row_t rows[12] = '{
    '{32'h00A00040, 32'hFFFFFFFF, 2'h1, 16'h0800, 16'h0000, 46, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h00C00040, 32'hFFFFFFFF, 2'h2, 16'h0800, 16'h0000, 46, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h02000040, 32'hFFFFFFFF, 2'h0, 16'h0800, 16'h0000, 46, -1, 20,
      1'b1, 1'b0, 1'b1},
    '{32'h00010040, 32'h0001FFFF, 2'h0, 16'h8100, 16'h0000, 46, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h00060040, 32'h000FFFFF, 2'h3, 16'h8808, 16'h0001, 46, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h000C0040, 32'h000FFFFF, 2'h3, 16'h8808, 16'h0005, 46, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h40000030, 32'h4000FFFF, 2'h0, 16'h0800, 16'h0000, 30, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h01000040, 32'h0100FFFF, 2'h0, 16'h0040, 16'h0000, 46, -1, 20,
      1'b0, 1'b0, 1'b1},
    '{32'h800005EF, 32'h8000FFFF, 2'h0, 16'h0800, 16'h0000, 1501, -1, 20,
      1'b0, 1'b0, 1'b0},
    '{32'h00000040, 32'h0080FFFF, 2'h0, 16'h0800, 16'h0000, 46, 20, 20,
      1'b0, 1'b0, 1'b1},
    '{32'h04000000, 32'h04000000, 2'h1, 16'h0800, 16'h0000, 46, -1, 20,
      1'b0, 1'b1, 1'b0},
    '{32'h20000000, 32'h20000000, 2'h1, 16'h0800, 16'h0000, 46, -1, 2,
      1'b0, 1'b0, 1'b0}};

  rmac_rx DUT (.clock, .rst, .rxd_pos(rxd), .rxd_neg(rxd[3:0]),
    .rxdv_pos(rxdv), .rxdv_neg(rxdv), .rxer_pos(rxer), .rxer_neg(rxer),
    .rxd, .rxdv, .rxer, .col, .crs, .rx_fifo_full, .rx_fifo_eof_out,
    .ignore_next_pkt, .rx_write, .rx_dbout, .rx_eof, .rx_error,
    .rx_fifo_error, .rx_stat_vector, .rx_stat_en, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  rmac_phy_model phy (.clock, .stall, .rx_write, .rx_dbout, .rx_eof,
    .rx_fifo_full, .rx_fifo_eof_out, .rxd, .rxdv, .rxer);

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Captures what the statistics strobe qualifies.
  always @(posedge clock) begin
    if (rx_stat_en === 1'b1) begin
      st_v   <= rx_stat_vector;
      st_err <= rx_error;
      st_eof <= rx_eof;
      got    <= 1'b1;
    end
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string what);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Register write; ready is judged mid-cycle, taken at the next edge.
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    @(negedge clock);
    while (!(s_axi_awready && s_axi_wready)) @(negedge clock);
    @(posedge clock);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    @(negedge clock);
    while (!s_axi_bvalid) @(negedge clock);
    resp = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask

  // Register read in the same manner.
  task automatic axi_rd(input logic [4:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(negedge clock);
    while (!s_axi_arready) @(negedge clock);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    @(negedge clock);
    while (!s_axi_rvalid) @(negedge clock);
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask

  // Builds a frame from a row, with its own reflected CRC-32 trailer.
  function automatic void mk(input rmac_row_t r);
    logic [31:0] c;
    logic [47:0] da;
    da = (r.dk == 2'h1) ? 48'hFFFFFFFFFFFF : (r.dk == 2'h2) ?
      48'h01005E000001 : (r.dk == 2'h3) ? 48'h0180C2000001 : 48'h020000000002;
    frm = {};
    for (int i = 5; i >= 0; i--) frm.push_back(da[8*i +: 8]);
    for (int i = 0; i < 6; i++) frm.push_back(8'h10 + 8'(i));
    frm.push_back(r.ty[15:8]);
    frm.push_back(r.ty[7:0]);
    for (int i = 0; i < r.plen; i++)
      frm.push_back((r.op == 16'h0000 || i > 1) ? 8'(i) : r.op[15-8*i -: 8]);
    c = 32'hFFFFFFFF;
    foreach (frm[i]) begin
      c = c ^ {24'h000000, frm[i]};
      for (int k = 0; k < 8; k++) c = (c >> 1) ^ (c[0] ? 32'hEDB88320 : 0);
    end
    c = ~c ^ {31'h00000000, r.bad};
    for (int i = 0; i < 4; i++) frm.push_back(c[8*i +: 8]);
    esum = 16'h0000;
    foreach (frm[i]) esum = esum + 16'(frm[i]);
  endfunction

  // Sends one row's frame and checks writes and the statistics.
  task automatic run(input rmac_row_t r);
    mk(r);
    phy.clear();
    got = 1'b0;
    @(posedge clock);
    ignore_next_pkt <= r.ign;
    phy.send(frm, r.erat, r.gap);
    for (int i = 0; i < 20 && !got; i++) @(negedge clock);
    chk(32'(got), 32'h1, "stat strobe");
    chk(32'(st_eof), 32'h1, "stat with eof");
    chk(st_v & r.mk, r.ev, "stat vector");
    chk(32'(st_v[28]), 32'h0, "spare bit");
    chk(32'(st_err), 32'(r.ee), "frame error");
    chk(32'(phy.n_wr), r.ign ? 0 : frm.size(), "writes");
    if (!r.ign) chk(32'(phy.sum), 32'(esum), "bytes");
  endtask

  // Main sequence: rows first, then hand-written cases.
  initial begin
    rst = 1'b1;
    {col, crs, ignore_next_pkt, stall} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    axi_wr(rmac_pkg::ADDR_CTRL, 32'h00000015);
    axi_wr(rmac_pkg::ADDR_IMASK, 32'h00000007);
    foreach (rows[i]) run(rows[i]);
    // Pending events raise the interrupt until written back.
    chk(32'(irq), 32'h1, "irq set");
    axi_wr(rmac_pkg::ADDR_ISTS, 32'h00000007);
    axi_rd(rmac_pkg::ADDR_ISTS);
    chk(d, 32'h00000000, "status cleared");
    chk(32'(irq), 32'h0, "irq clear");
    axi_wr(rmac_pkg::ADDR_IMASK, 32'h00000000);
    run(rows[0]);
    chk(32'(irq), 32'h0, "irq masked");
    axi_rd(rmac_pkg::ADDR_STAT);
    chk(d, 32'h00A00040, "stat register");
    // Double-edge pins at full rate.
    axi_wr(rmac_pkg::ADDR_CTRL, 32'h00000011);
    run(rows[2]);
    run(rows[9]);
    axi_wr(rmac_pkg::ADDR_CTRL, 32'h00000015);
    // FIFO full in mid-frame stops writes until the frame end drains.
    mk(rows[0]);
    phy.clear();
    fork
      phy.send(frm, -1, 4);
      begin
        repeat (20) @(posedge clock);
        stall <= 1'b1;
      end
    join
    @(negedge clock);
    chk(32'(rx_fifo_error), 32'h1, "fifo error");
    chk(32'(phy.n_wr < 64 && phy.n_wr > 0), 32'h1, "writes held");
    @(posedge clock);
    stall <= 1'b0;
    repeat (12) @(negedge clock);
    chk(32'(rx_fifo_error), 32'h0, "fifo error release");
    axi_rd(rmac_pkg::ADDR_ISTS);
    chk(32'(d[2]), 32'h1, "fifo error status");
    // Half duplex at 10/100.
    axi_wr(rmac_pkg::ADDR_CTRL, 32'h00000029);
    phy.hold = 2;
    {crs, col} <= 2'h3;
    rows[0].ev = 32'h08200040;
    run(rows[0]);
    // Reset in mid-run restores the defaults.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(rx_stat_vector, 32'h00000000, "vector after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    axi_rd(rmac_pkg::ADDR_CTRL);
    chk(d, 32'(rmac_pkg::CTRL_RST), "ctrl default");
    axi_rd(rmac_pkg::ADDR_MAXLEN);
    chk(d, 32'(rmac_pkg::MAXLEN_RST), "maxlen default");
    axi_rd(5'h14);
    chk({d[29:0], resp}, 32'(rmac_pkg::RESP_ERR), "unmapped");
    wrap_up();
  end

  // Ends a hung run.
  initial begin
    #300000;
    n_errors++;
    wrap_up();
  end
endmodule // rx_mac_receive_side_interface_tb
